// ### logic/mcfg_pkg.sv
`default_nettype none
package mcfg_pkg;

   // ===========================================================
   // register map (word aligned byte addresses)
   // ===========================================================
   localparam logic [7:0] ADDR_RESET_FLOW = 8'h00;
   localparam logic [7:0] ADDR_FRAME_FMT = 8'h04;
   localparam logic [7:0] ALIAS_CLR = 8'h10;
   localparam logic [7:0] ALIAS_SET = 8'h20;
   localparam logic [7:0] ALIAS_INV = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h40;

   // ===========================================================
   // field positions, first register
   // ===========================================================
   localparam int B_WHOLE_MAC_RESET = 15;
   localparam int B_TX_RANDOM_GEN_RESET = 14;
   localparam int B_CTRL_SUBLAYER_RX_RESET = 11;
   localparam int B_RX_FUNCTION_RESET = 10;
   localparam int B_CTRL_SUBLAYER_TX_RESET = 9;
   localparam int B_TX_FUNCTION_RESET = 8;
   localparam int B_LOOPBACK = 4;
   localparam int B_TX_FLOW_CTRL_ALLOW = 3;
   localparam int B_RX_FLOW_CTRL_HONOR = 2;
   localparam int B_ACCEPT_CONTROL_FRAMES = 1;
   localparam int B_RECEIVE_ON = 0;
   localparam logic [31:0] CFG1_WMASK = 32'h0000_CF1F;
   localparam logic [31:0] CFG1_RESET = 32'h0000_800D;

   // ===========================================================
   // field positions, second register
   // ===========================================================
   localparam int B_TAG_AWARE_PAD = 7;
   localparam int B_TAGGED_PAD_64 = 6;
   localparam int B_SHORT_FRAME_PAD_ON = 5;
   localparam int B_FCS_APPEND_ON = 4;
   localparam int B_HEADER_SKIP_FCS = 3;
   localparam int B_OVERSIZE_FRAME_ALLOW = 2;
   localparam int B_LENGTH_FIELD_CHECK = 1;
   localparam int B_DUPLEX_SELECT = 0;
   localparam logic [31:0] CFG2_WMASK = 32'h0000_00FF;
   localparam logic [31:0] CFG2_RESET = 32'h0000_0000;

   // ===========================================================
   // frame sizing
   // ===========================================================
   localparam logic [6:0] PAD_LEN_PLAIN = 7'd60;
   localparam logic [6:0] PAD_LEN_TAGGED = 7'd64;
   localparam logic [2:0] HEADER_SKIP_BYTES = 3'd4;

   typedef struct packed {
      logic whole_mac_reset;
      logic tx_random_gen_reset;
      logic ctrl_sublayer_rx_reset;
      logic rx_function_reset;
      logic ctrl_sublayer_tx_reset;
      logic tx_function_reset;
   } mcfg_resets_t;

   typedef struct packed {
      logic pad_on;
      logic fcs_append;
      logic fcs_check;
      logic [6:0] pad_len_untagged;
      logic [6:0] pad_len_tagged;
      logic [2:0] fcs_skip_bytes;
   } mcfg_pad_ctrl_t;

endpackage

`default_nettype wire

// ### logic/mcfg_top.sv
`timescale 1ns/1ps
`default_nettype none

module mcfg_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // per-frame qualifiers from the mac datapath
   input wire logic rx_frame_is_pause,
   input wire logic rx_frame_is_control,
   input wire logic tx_pause_request,
   input wire logic tx_frame_tagged,
   input wire logic [15:0] tx_frame_len,
   input wire logic [15:0] rx_frame_len,
   input wire logic [15:0] max_frame_len,
   // datapath enables and resets
   output mcfg_pkg::mcfg_resets_t domain_resets,
   output logic loopback_on,
   output logic tx_pause_grant,
   output logic rx_pause_act,
   output logic rx_accept_control,
   output logic receive_on,
   output logic header_skip_fcs,
   output logic length_field_check,
   output logic duplex_select,
   output logic tx_len_ok,
   output logic rx_len_ok,
   output mcfg_pkg::mcfg_pad_ctrl_t pad_ctrl,
   output logic [6:0] tx_pad_target
);

   // ===========================================================
   // apb decode
   // ===========================================================
   logic [31:0] cfg1;
   logic [31:0] cfg2;
   logic [7:0] base;
   logic [7:0] alias_sel;
   logic hit1;
   logic hit2;
   logic hit_stat;
   logic mapped;
   logic wide_ok;
   logic wr_fire;
   logic [31:0] lane_mask;

   function automatic logic [31:0] apply_write(input logic [31:0] cur,
                                              input logic [31:0] wdat,
                                              input logic [31:0] lanes,
                                              input logic [7:0] asel,
                                              input logic [31:0] wmask);
      logic [31:0] m;
      logic [31:0] nv;
      m = lanes & wmask;
      case (asel)
         mcfg_pkg::ALIAS_CLR: nv = cur & ~(wdat & m);
         mcfg_pkg::ALIAS_SET: nv = cur | (wdat & m);
         mcfg_pkg::ALIAS_INV: nv = cur ^ (wdat & m);
         default: nv = (cur & ~m) | (wdat & m);
      endcase
      return nv;
   endfunction

   assign alias_sel = paddr & 8'h30;
   assign base = paddr & 8'hCF;
   assign hit1 = (base == mcfg_pkg::ADDR_RESET_FLOW);
   assign hit2 = (base == mcfg_pkg::ADDR_FRAME_FMT);
   assign hit_stat = (paddr == mcfg_pkg::ADDR_STATUS);
   assign mapped = hit1 | hit2 | hit_stat;
   // a write is halfword or word only; single-byte strobes are dropped
   assign wide_ok = (pstrb == 4'hF) || (pstrb == 4'h3) || (pstrb == 4'hC);
   assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wr_fire = psel & penable & pwrite & wide_ok;
   assign pready = 1'b1;
   // unmapped addresses error; byte writes are silently ignored, not errored
   assign pslverr = psel & penable & ~mapped;

   // ===========================================================
   // configuration registers
   // ===========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg1 <= mcfg_pkg::CFG1_RESET;
      end else if (wr_fire && hit1) begin
         // reset bits are plain storage: logic stays reset until cleared
         cfg1 <= apply_write(cfg1, pwdata, lane_mask, alias_sel, mcfg_pkg::CFG1_WMASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg2 <= mcfg_pkg::CFG2_RESET;
      end else if (wr_fire && hit2) begin
         cfg2 <= apply_write(cfg2, pwdata, lane_mask, alias_sel, mcfg_pkg::CFG2_WMASK);
      end
   end

   // ===========================================================
   // readback
   // ===========================================================
   logic [31:0] status_word;
   assign status_word = {26'h0, tx_len_ok, rx_len_ok, rx_pause_act,
                         tx_pause_grant, domain_resets.whole_mac_reset, receive_on};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (hit1) begin
            prdata <= cfg1;
         end else if (hit2) begin
            prdata <= cfg2;
         end else if (hit_stat) begin
            prdata <= status_word;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ===========================================================
   // reset fan-out
   // ===========================================================
   logic all_rst;
   assign all_rst = cfg1[mcfg_pkg::B_WHOLE_MAC_RESET];

   always_comb begin
      domain_resets.whole_mac_reset = all_rst;
      // simulation reset touches the random generator only
      domain_resets.tx_random_gen_reset = cfg1[mcfg_pkg::B_TX_RANDOM_GEN_RESET] | all_rst;
      domain_resets.ctrl_sublayer_rx_reset =
         cfg1[mcfg_pkg::B_CTRL_SUBLAYER_RX_RESET] | all_rst;
      domain_resets.rx_function_reset = cfg1[mcfg_pkg::B_RX_FUNCTION_RESET] | all_rst;
      domain_resets.ctrl_sublayer_tx_reset =
         cfg1[mcfg_pkg::B_CTRL_SUBLAYER_TX_RESET] | all_rst;
      domain_resets.tx_function_reset = cfg1[mcfg_pkg::B_TX_FUNCTION_RESET] | all_rst;
   end

   // ===========================================================
   // receive and flow control qualifiers
   // ===========================================================
   logic rx_live;
   logic tx_live;
   assign rx_live = ~domain_resets.rx_function_reset;
   assign tx_live = ~domain_resets.ctrl_sublayer_tx_reset;

   assign loopback_on = cfg1[mcfg_pkg::B_LOOPBACK];
   assign tx_pause_grant = tx_pause_request & cfg1[mcfg_pkg::B_TX_FLOW_CTRL_ALLOW] & tx_live;
   assign rx_pause_act = rx_frame_is_pause & cfg1[mcfg_pkg::B_RX_FLOW_CTRL_HONOR]
                         & ~domain_resets.ctrl_sublayer_rx_reset & receive_on;
   // with pass-all clear a control frame is dropped before delivery
   assign rx_accept_control = receive_on &
      (~rx_frame_is_control | cfg1[mcfg_pkg::B_ACCEPT_CONTROL_FRAMES]);
   assign receive_on = cfg1[mcfg_pkg::B_RECEIVE_ON] & rx_live;

   // ===========================================================
   // frame format
   // ===========================================================
   logic pad_en;
   logic vlan_pad;
   logic auto_pad;
   logic huge_ok;
   assign pad_en = cfg2[mcfg_pkg::B_SHORT_FRAME_PAD_ON];
   assign vlan_pad = cfg2[mcfg_pkg::B_TAGGED_PAD_64];
   assign auto_pad = cfg2[mcfg_pkg::B_TAG_AWARE_PAD];
   assign huge_ok = cfg2[mcfg_pkg::B_OVERSIZE_FRAME_ALLOW];
   assign header_skip_fcs = cfg2[mcfg_pkg::B_HEADER_SKIP_FCS];
   assign length_field_check = cfg2[mcfg_pkg::B_LENGTH_FIELD_CHECK];
   assign duplex_select = cfg2[mcfg_pkg::B_DUPLEX_SELECT];

   // length limit applies both ways unless huge frames are allowed
   assign tx_len_ok = huge_ok | (tx_frame_len <= max_frame_len);
   assign rx_len_ok = huge_ok | (rx_frame_len <= max_frame_len);

   always_comb begin
      pad_ctrl.pad_on = pad_en;
      // pad enable forces crc append on by itself; append follows either bit
      pad_ctrl.fcs_append = pad_en | cfg2[mcfg_pkg::B_FCS_APPEND_ON];
      pad_ctrl.fcs_check = ~pad_en;
      pad_ctrl.fcs_skip_bytes = header_skip_fcs ? mcfg_pkg::HEADER_SKIP_BYTES : 3'd0;
      if (!pad_en) begin
         pad_ctrl.pad_len_untagged = 7'd0;
         pad_ctrl.pad_len_tagged = 7'd0;
      end else if (vlan_pad) begin
         pad_ctrl.pad_len_untagged = mcfg_pkg::PAD_LEN_TAGGED;
         pad_ctrl.pad_len_tagged = mcfg_pkg::PAD_LEN_TAGGED;
      end else if (auto_pad) begin
         pad_ctrl.pad_len_untagged = mcfg_pkg::PAD_LEN_PLAIN;
         pad_ctrl.pad_len_tagged = mcfg_pkg::PAD_LEN_TAGGED;
      end else begin
         pad_ctrl.pad_len_untagged = mcfg_pkg::PAD_LEN_PLAIN;
         pad_ctrl.pad_len_tagged = mcfg_pkg::PAD_LEN_PLAIN;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pad_target <= 7'd0;
      end else begin
         tx_pad_target <= tx_frame_tagged ? pad_ctrl.pad_len_tagged : pad_ctrl.pad_len_untagged;
      end
   end

endmodule

`default_nettype wire

// ### tb/mcfg_dp_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side datapath: qualifiers change every cycle, nothing held for the block
module mcfg_dp_model (
   input wire logic clk,
   output logic rx_pause,
   output logic rx_ctl,
   output logic tx_preq,
   output logic tx_tag,
   output logic [15:0] tx_len,
   output logic [15:0] rx_len,
   output logic [15:0] max_len
);
   initial begin
      {rx_pause, rx_ctl, tx_preq, tx_tag} = 4'h0;
      {tx_len, rx_len, max_len} = 48'h0;
   end
   always @(posedge clk) begin
      {rx_pause, rx_ctl, tx_preq, tx_tag} <= 4'($urandom);
      tx_len <= 16'($urandom_range(2047));
      rx_len <= 16'($urandom_range(2047));
      max_len <= 16'($urandom_range(2047));
   end
endmodule
`default_nettype wire

// ### tb/mcfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic tx_pause_request,
   input wire logic tx_frame_tagged,
   input wire mcfg_pkg::mcfg_resets_t domain_resets,
   input wire logic loopback_on,
   input wire logic tx_pause_grant,
   input wire logic rx_pause_act,
   input wire logic rx_accept_control,
   input wire logic receive_on,
   input wire mcfg_pkg::mcfg_pad_ctrl_t pad_ctrl,
   input wire logic [6:0] tx_pad_target
);
   // ==========
   // gating
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr_cfg1;
      psel && penable && pwrite && pstrb == 4'hF && paddr == mcfg_pkg::ADDR_RESET_FLOW;
   endsequence
   a_whole_all: assert property (
      domain_resets.whole_mac_reset |-> &domain_resets && !receive_on)
      else $error("soft reset not spread");
   a_rx_func_gate: assert property (
      domain_resets.rx_function_reset |-> !receive_on)
      else $error("receive on during reset");
   a_tx_pause_gate: assert property (
      tx_pause_grant |-> tx_pause_request && !domain_resets.ctrl_sublayer_tx_reset)
      else $error("pause grant wrong");
   a_rx_pause_gate: assert property (
      rx_pause_act |-> receive_on && !domain_resets.ctrl_sublayer_rx_reset)
      else $error("pause act wrong");
   a_ctrl_gate: assert property (
      rx_accept_control |-> receive_on)
      else $error("control accepted while off");
   a_pad_fcs_tie: assert property (
      pad_ctrl.pad_on |-> pad_ctrl.fcs_append && !pad_ctrl.fcs_check)
      else $error("pad without fcs append");
   a_pad_target: assert property (
      1'b1 |=> tx_pad_target == ($past(tx_frame_tagged) ?
         $past(pad_ctrl.pad_len_tagged) : $past(pad_ctrl.pad_len_untagged)))
      else $error("pad target wrong");
   a_wr_cfg1: assert property (
      s_wr_cfg1 |=> domain_resets.whole_mac_reset == $past(pwdata[15])
         && loopback_on == $past(pwdata[4])
         && receive_on == ($past(pwdata[0]) && !$past(pwdata[10]) && !$past(pwdata[15])))
      else $error("word write not applied");
   a_byte_ignored: assert property (
      psel && penable && pwrite && pstrb == 4'h1 |=> $stable(loopback_on) && $stable(domain_resets))
      else $error("byte write took effect");
endmodule
`default_nettype wire

// ### tb/mcfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcfg_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, c1, c2;
   logic [3:0] pstrb;
   logic rp, rc, tq, tt, lb, tg, ra, rac, ron, hs, lc, dx, tok, rok;
   logic [15:0] tl, rl, ml;
   logic [6:0] tpt;
   mcfg_pkg::mcfg_resets_t dr;
   mcfg_pkg::mcfg_pad_ctrl_t pc;
   logic [32:0] expq[$];
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int bits[6] = '{15, 14, 11, 10, 9, 8};
   mcfg_top mcfg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_frame_is_pause(rp), .rx_frame_is_control(rc),
      .tx_pause_request(tq), .tx_frame_tagged(tt), .tx_frame_len(tl), .rx_frame_len(rl),
      .max_frame_len(ml), .domain_resets(dr), .loopback_on(lb), .tx_pause_grant(tg),
      .rx_pause_act(ra), .rx_accept_control(rac), .receive_on(ron), .header_skip_fcs(hs),
      .length_field_check(lc), .duplex_select(dx), .tx_len_ok(tok), .rx_len_ok(rok),
      .pad_ctrl(pc), .tx_pad_target(tpt));
   mcfg_dp_model mcfg_dp_model_i (.clk(pclk), .rx_pause(rp), .rx_ctl(rc), .tx_preq(tq),
      .tx_tag(tt), .tx_len(tl), .rx_len(rl), .max_len(ml));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task report_and_stop;
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0000_0000, 4'hF);
   endtask
   // ==========
   // read results: slave error flag and data against oldest note
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("read", expq.pop_front(), {pslverr, prdata});
   end
   task automatic out_chk;
      logic w, ro;
      logic [6:0] pu, pt;
      @(negedge pclk);
      w = c1[15];
      ro = c1[0] & ~(c1[10] | w);
      pu = c2[6] ? mcfg_pkg::PAD_LEN_TAGGED : mcfg_pkg::PAD_LEN_PLAIN;
      pt = (c2[6] | c2[7]) ? mcfg_pkg::PAD_LEN_TAGGED : mcfg_pkg::PAD_LEN_PLAIN;
      if (!c2[5]) {pu, pt} = 14'h0000;
      chk("resets", 33'({w, {5{w}} | {c1[14], c1[11:8]}}), 33'(dr));
      chk("gates", 33'({tq & c1[3] & ~(c1[9] | w), rp & c1[2] & ~(c1[11] | w) & ro,
         ro & (~rc | c1[1]), ro}), 33'({tg, ra, rac, ron}));
      chk("modes", 33'({c1[4], c2[3], c2[1], c2[0]}), 33'({lb, hs, lc, dx}));
      chk("len", 33'({c2[2] | (tl <= ml), c2[2] | (rl <= ml)}), 33'({tok, rok}));
      chk("pad", 33'({c2[5], c2[5] | c2[4], ~c2[5], pu, pt,
         c2[3] ? mcfg_pkg::HEADER_SKIP_BYTES : 3'h0}), 33'(pc));
   endtask
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      c1 = mcfg_pkg::CFG1_RESET;
      c2 = 32'h0000_0000;
      void'($urandom(40962));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      out_chk();
      rd(mcfg_pkg::ADDR_RESET_FLOW, {1'b0, c1});
      rd(mcfg_pkg::ADDR_FRAME_FMT, 33'h0_0000_0000);
      rd(8'h08, 33'h1_0000_0000);
      apb(1'b1, mcfg_pkg::ADDR_RESET_FLOW, 32'h0000_0000, 4'h1);
      rd(mcfg_pkg::ADDR_RESET_FLOW, {1'b0, c1});
      apb(1'b1, mcfg_pkg::ADDR_RESET_FLOW, 32'hFFFF_001F, 4'h3);
      c1 = 32'h0000_001F;
      out_chk();
      foreach (bits[i]) begin
         apb(1'b1, mcfg_pkg::ALIAS_SET, 32'h1 << bits[i], 4'hF);
         c1[bits[i]] = 1'b1;
         out_chk();
         apb(1'b1, mcfg_pkg::ALIAS_CLR, 32'h1 << bits[i], 4'h3);
         c1[bits[i]] = 1'b0;
         out_chk();
      end
      apb(1'b1, mcfg_pkg::ALIAS_INV, 32'h0000_0010, 4'hF);
      c1 = c1 ^ 32'h0000_0010;
      rd(mcfg_pkg::ADDR_RESET_FLOW, {1'b0, c1});
      repeat (30) begin
         c1 = $urandom & mcfg_pkg::CFG1_WMASK;
         c2 = $urandom & mcfg_pkg::CFG2_WMASK;
         c2[4] = c2[4] | c2[5];
         apb(1'b1, mcfg_pkg::ADDR_RESET_FLOW, c1, 4'hF);
         apb(1'b1, mcfg_pkg::ADDR_FRAME_FMT, c2, 4'hF);
         rd(mcfg_pkg::ADDR_FRAME_FMT, {1'b0, c2});
         repeat (3) out_chk();
      end
      // second reset in mid-run: registers must fall back to their power-up values
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      c1 = mcfg_pkg::CFG1_RESET;
      c2 = 32'h0000_0000;
      out_chk();
      rd(mcfg_pkg::ADDR_RESET_FLOW, {1'b0, c1});
      rd(mcfg_pkg::ADDR_FRAME_FMT, {1'b0, c2});
      report_and_stop();
   end
endmodule
bind mcfg_top mcfg_props mcfg_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .tx_pause_request(tx_pause_request), .tx_frame_tagged(tx_frame_tagged),
   .domain_resets(domain_resets), .loopback_on(loopback_on), .tx_pause_grant(tx_pause_grant),
   .rx_pause_act(rx_pause_act), .rx_accept_control(rx_accept_control),
   .receive_on(receive_on), .pad_ctrl(pad_ctrl), .tx_pad_target(tx_pad_target));
`default_nettype wire
